// File: rtl/cpu_register_file_and_flags.sv
// cpu general registers, program counter and condition flags
// assumes the core sequencer supplies write, flag and pc commands each cycle
`timescale 1ns/1ps
`default_nettype none
module cpu_register_file_and_flags
  import cpu_regs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register write and read
  input wire reg_write_s regWrite,
  input wire logic [2:0] readIdx,
  input wire part_e readPart,
  output logic [31:0] readData,
  output logic [31:0] stackPointer,
  // flag update
  input wire flag_update_s flagUpdate,
  input wire logic [7:0] flagImm,
  output logic [7:0] conditionFlags,
  // program counter
  input wire logic [23:0] resetVector,
  input wire logic resetLoad,
  input wire logic pcLoad,
  input wire logic [23:0] pcValue,
  output logic [23:0] programCounter,
  output logic [23:0] fetchAddr,
  // address forming
  input wire logic narrowSpace,
  input wire logic [31:0] effAddr,
  input wire logic wideAccess,
  output logic [23:0] busAddr,
  // exceptions and interrupts
  input wire logic exceptionStart,
  input wire logic useUiMask,
  input wire logic irqRequest,
  input wire logic nmiRequest,
  output logic irqAccept,
  output logic nmiAccept
);

  ////////////////////////////////////////////////////////////////////////
  logic [31:0] wideGpRegs [REG_CNT];
  logic [31:0] next_wideGpRegs [REG_CNT];
  logic [7:0] flags;
  logic [7:0] next_flags;
  logic [23:0] pc;
  logic [23:0] next_pc;

  // merge a partial write into a register value
  function automatic logic [31:0] mergePart(input logic [31:0] old, input part_e p,
                                            input logic [31:0] d);
    logic [31:0] r;
    r = old;
    case (p)
      PART_LONG: r = d;
      PART_EXT: r[31:16] = d[15:0];
      PART_BASE: r[15:0] = d[15:0];
      PART_HIGH: r[15:8] = d[7:0];
      PART_LOW: r[7:0] = d[7:0];
      default: r = old;
    endcase
    return r;
  endfunction

  // read one part, zero extended
  function automatic logic [31:0] readPartOf(input logic [31:0] v, input part_e p);
    logic [31:0] r;
    r = 32'h00000000;
    case (p)
      PART_LONG: r = v;
      PART_EXT: r[15:0] = v[31:16];
      PART_BASE: r[15:0] = v[15:0];
      PART_HIGH: r[7:0] = v[15:8];
      PART_LOW: r[7:0] = v[7:0];
      default: r = 32'h00000000;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // general registers
  always_comb begin
    for (int i = 0; i < REG_CNT; i++) begin
      next_wideGpRegs[i] = wideGpRegs[i];
    end
    if (regWrite.wen) begin
      next_wideGpRegs[regWrite.idx] = mergePart(wideGpRegs[regWrite.idx], regWrite.part,
                                                regWrite.data);
    end
  end

  // no reset: registers and stack pointer stay uninitialised
  always_ff @(posedge clk) begin
    for (int i = 0; i < REG_CNT; i++) begin
      wideGpRegs[i] <= next_wideGpRegs[i];
    end
  end

  always_comb begin
    readData = readPartOf(wideGpRegs[readIdx], readPart);
    stackPointer = wideGpRegs[STACK_IDX];
  end

  ////////////////////////////////////////////////////////////////////////
  // flag computation
  logic [32:0] sum;
  logic [4:0] lowSum;
  logic [12:0] midSum;
  logic [28:0] upSum;
  logic [31:0] opA;
  logic [31:0] opB;
  logic carryIn;
  logic isSub;
  logic isArith;
  logic signA;
  logic signB;
  logic signR;
  logic resZero;
  logic carryOut;
  logic halfOut;

  always_comb begin
    isSub = (flagUpdate.op == OP_SUB) || (flagUpdate.op == OP_SUBX) ||
            (flagUpdate.op == OP_CMP) || (flagUpdate.op == OP_NEG);
    isArith = isSub || (flagUpdate.op == OP_ADD) || (flagUpdate.op == OP_ADDX);
    opA = (flagUpdate.op == OP_NEG) ? 32'h00000000 : flagUpdate.a;
    opB = isSub ? ~flagUpdate.b : flagUpdate.b;
    carryIn = 1'b0;
    if (flagUpdate.op == OP_ADDX) begin
      carryIn = flags[FLAG_CARRY];
    end else if (flagUpdate.op == OP_SUBX) begin
      carryIn = ~flags[FLAG_CARRY];
    end else if (isSub) begin
      carryIn = 1'b1;
    end
    sum = {1'b0, opA} + {1'b0, opB} + {32'h00000000, carryIn};
    lowSum = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
    midSum = {1'b0, opA[11:0]} + {1'b0, opB[11:0]} + {12'h000, carryIn};
    upSum = {1'b0, opA[27:0]} + {1'b0, opB[27:0]} + {28'h0000000, carryIn};
    signA = opA[31];
    signB = opB[31];
    signR = flagUpdate.result[31];
    resZero = (flagUpdate.result == 32'h00000000);
    carryOut = sum[32];
    halfOut = upSum[28];
    case (flagUpdate.size)
      SZ_BYTE: begin
        signA = opA[7];
        signB = opB[7];
        signR = flagUpdate.result[7];
        resZero = (flagUpdate.result[7:0] == 8'h00);
        carryOut = sum[8] ^ opA[8] ^ opB[8];
        halfOut = lowSum[4];
      end
      SZ_WORD: begin
        signA = opA[15];
        signB = opB[15];
        signR = flagUpdate.result[15];
        resZero = (flagUpdate.result[15:0] == 16'h0000);
        carryOut = sum[16] ^ opA[16] ^ opB[16];
        halfOut = midSum[12];
      end
      default: begin
      end
    endcase
  end

  always_comb begin
    next_flags = flags;
    if (isArith) begin
      next_flags[FLAG_HALF] = isSub ? ~halfOut : halfOut;
      next_flags[FLAG_NEG] = signR;
      if (flagUpdate.op == OP_ADDX || flagUpdate.op == OP_SUBX) begin
        next_flags[FLAG_ZERO] = flags[FLAG_ZERO] & resZero;
      end else begin
        next_flags[FLAG_ZERO] = resZero;
      end
      next_flags[FLAG_OVF] = (signA == signB) && (signR != signA);
      next_flags[FLAG_CARRY] = isSub ? ~carryOut : carryOut;
    end else if (flagUpdate.op == OP_LOGIC) begin
      next_flags[FLAG_NEG] = signR;
      next_flags[FLAG_ZERO] = resZero;
      next_flags[FLAG_OVF] = 1'b0;
    end else if (flagUpdate.op == OP_SHIFT) begin
      next_flags[FLAG_NEG] = signR;
      next_flags[FLAG_ZERO] = resZero;
      next_flags[FLAG_OVF] = 1'b0;
      next_flags[FLAG_CARRY] = flagUpdate.shiftOut;
    end else if (flagUpdate.op == OP_BIT) begin
      next_flags[FLAG_CARRY] = flagUpdate.bitValue;
    end else if (flagUpdate.op == OP_LDFLAG) begin
      next_flags = flagImm;
    end else if (flagUpdate.op == OP_ANDFLAG) begin
      next_flags = flags & flagImm;
    end else if (flagUpdate.op == OP_ORFLAG) begin
      next_flags = flags | flagImm;
    end else if (flagUpdate.op == OP_XORFLAG) begin
      next_flags = flags ^ flagImm;
    end
    if (exceptionStart) begin
      next_flags[FLAG_IMASK] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= FLAG_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  assign conditionFlags = flags;

  ////////////////////////////////////////////////////////////////////////
  // program counter
  always_comb begin
    next_pc = pc;
    if (resetLoad) begin
      next_pc = resetVector;
    end else if (pcLoad) begin
      next_pc = pcValue;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc <= PC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  assign programCounter = pc;
  assign fetchAddr = {pc[23:1], 1'b0};

  ////////////////////////////////////////////////////////////////////////
  // address forming: 24-bit linear space, or 20-bit with the top 4 bits zero when narrowSpace is set
  logic [23:0] linAddr;
  always_comb begin
    linAddr = effAddr[23:0];
    if (narrowSpace) begin
      linAddr = {4'h0, effAddr[NARROW_ADDR_W-1:0]};
    end
    if (wideAccess) begin
      linAddr[0] = 1'b0;
    end
    busAddr = linAddr;
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt acceptance
  always_comb begin
    nmiAccept = nmiRequest;
    irqAccept = irqRequest && !nmiRequest && !flags[FLAG_IMASK] &&
                !(useUiMask && flags[FLAG_UIMASK]);
  end

endmodule
`default_nettype wire

// File: rtl/cpu_regs_pkg.sv
// package for the cpu register file and flag logic
// assumes a single clock domain driven by the cpu core
package cpu_regs_pkg;
  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam int BYTE_W = 8;
  localparam int REG_CNT = 8;
  localparam int REG_IDX_W = 3;
  localparam int PC_W = 24;
  localparam int FLAG_W = 8;
  localparam logic [2:0] STACK_IDX = 3'h7;
  localparam int NARROW_ADDR_W = 20;
  // flag bit positions
  localparam int FLAG_IMASK = 7;
  localparam int FLAG_UIMASK = 6;
  localparam int FLAG_HALF = 5;
  localparam int FLAG_USER = 4;
  localparam int FLAG_NEG = 3;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_OVF = 1;
  localparam int FLAG_CARRY = 0;
  // half-carry positions per size
  localparam int HC_BYTE = 3;
  localparam int HC_WORD = 11;
  localparam int HC_LONG = 27;
  localparam logic [7:0] FLAG_RESET = 8'h80;
  localparam logic [23:0] PC_RESET = 24'h000000;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} size_e;
  // register part selector: long, extended half, base half, high byte, low byte
  typedef enum logic [2:0] {PART_LONG, PART_EXT, PART_BASE, PART_HIGH, PART_LOW} part_e;
  typedef enum logic [3:0] {
    OP_NONE, OP_ADD, OP_ADDX, OP_SUB, OP_SUBX, OP_CMP, OP_NEG, OP_LOGIC,
    OP_SHIFT, OP_BIT, OP_LDFLAG, OP_ANDFLAG, OP_ORFLAG, OP_XORFLAG
  } alu_op_e;

  typedef struct packed {
    logic wen;
    logic [2:0] idx;
    part_e part;
    logic [31:0] data;
  } reg_write_s;

  typedef struct packed {
    alu_op_e op;
    size_e size;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] result;
    logic shiftOut;
    logic bitValue;
  } flag_update_s;
endpackage

// File: dv/cpu_regs_checker.sv
// assertions for the register file and flag logic
// bound to the top module, one clock domain
`timescale 1ns/1ps
`default_nettype none
module cpu_regs_checker
  import cpu_regs_pkg::*;
(
  // clock, reset and requests
  input wire logic clk,
  input wire logic rst_n,
  input wire reg_write_s regWrite,
  input wire flag_update_s flagUpdate,
  input wire logic exceptionStart,
  input wire logic resetLoad,
  input wire logic [23:0] resetVector,
  input wire logic narrowSpace,
  input wire logic wideAccess,
  input wire logic nmiRequest,
  // outputs watched
  input wire logic irqAccept,
  input wire logic nmiAccept,
  input wire logic [31:0] stackPointer,
  input wire logic [7:0] conditionFlags,
  input wire logic [23:0] programCounter,
  input wire logic [23:0] fetchAddr,
  input wire logic [23:0] busAddr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_fetch_even: assert property (fetchAddr == {programCounter[23:1], 1'b0})
    else $error("fetch address not even");
  a_mask_irq: assert property (conditionFlags[7] |-> !irqAccept)
    else $error("irq accepted while masked");
  a_nmi_taken: assert property (nmiRequest |-> nmiAccept)
    else $error("nmi not accepted");
  a_exc_mask: assert property (exceptionStart |=> conditionFlags[7])
    else $error("mask bit not set on exception");
  a_narrow_top: assert property (narrowSpace |-> busAddr[23:20] == 4'h0)
    else $error("upper address bits kept in narrow space");
  a_wide_even: assert property (wideAccess |-> !busAddr[0])
    else $error("wide access at odd address");
  a_sp_long: assert property (regWrite.wen && regWrite.idx == 3'h7 &&
    regWrite.part == PART_LONG |=> stackPointer == $past(regWrite.data))
    else $error("stack pointer not updated");
  a_pc_vector: assert property (resetLoad |=> programCounter == $past(resetVector))
    else $error("pc not loaded from vector");
  a_flags_kept: assert property (flagUpdate.op == OP_NONE && !exceptionStart
    |=> $stable(conditionFlags))
    else $error("flags changed without an op");
  cover property (exceptionStart);
  cover property (nmiRequest && conditionFlags[7]);
  cover property (narrowSpace && wideAccess);
endmodule
bind cpu_register_file_and_flags cpu_regs_checker i_cpu_regs_checker (.clk, .rst_n,
  .regWrite, .flagUpdate, .exceptionStart, .resetLoad, .resetVector, .narrowSpace,
  .wideAccess, .nmiRequest, .irqAccept, .nmiAccept, .stackPointer, .conditionFlags,
  .programCounter, .fetchAddr, .busAddr);
`default_nettype wire

// File: dv/cpu_register_file_and_flags_test.sv
// self-checking bench for the register file and flags
// drives every port itself, no partner model
`timescale 1ns/1ps
`default_nettype none
module cpu_register_file_and_flags_test
  import cpu_regs_pkg::*;
;
  logic clk = '0;
  logic rst_n = '0;
  reg_write_s regWrite = '0;
  flag_update_s flagUpdate = '0;
  part_e readPart = PART_LONG;
  logic [2:0] readIdx = '0;
  logic [31:0] effAddr = '0, readData, stackPointer;
  logic [7:0] flagImm = '0, conditionFlags;
  logic [23:0] resetVector = '0, pcValue = '0, programCounter, fetchAddr, busAddr;
  logic resetLoad = '0, pcLoad = '0, narrowSpace = '0, wideAccess = '0;
  logic exceptionStart = '0, useUiMask = '0, irqRequest = '0, nmiRequest = '0;
  logic irqAccept, nmiAccept;
  int n_mismatch = 0, checks_done = 0, cycles = 0;

  cpu_register_file_and_flags i_cpu_register_file_and_flags (.clk, .rst_n, .regWrite,
    .readIdx, .readPart, .readData, .stackPointer, .flagUpdate, .flagImm,
    .conditionFlags, .resetVector, .resetLoad, .pcLoad, .pcValue, .programCounter,
    .fetchAddr, .narrowSpace, .effAddr, .wideAccess, .busAddr, .exceptionStart,
    .useUiMask, .irqRequest, .nmiRequest, .irqAccept, .nmiAccept);

  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic step(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("summary errors %0d comparisons %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic flag_op(alu_op_e op, size_e sz, logic [31:0] a, b, res,
                         logic [7:0] imm, logic [7:0] exp);
    flagUpdate = '{op, sz, a, b, res, 1'b1, 1'b0};
    flagImm = imm;
    step();
    flagUpdate.op = OP_NONE;
    check("flags", 32'(conditionFlags), 32'(exp));
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset_pc();
    check("flags", 32'(conditionFlags), 32'h80);
    check("pc", 32'(programCounter), 32'h0);
    rst_n = '1;
    resetVector = 24'hABCDEF;
    resetLoad = '1;
    step();
    resetLoad = '0;
    pcLoad = '1;
    pcValue = 24'h123457;
    check("pc", 32'(programCounter), 32'hABCDEF);
    step();
    pcLoad = '0;
    check("fetch", 32'(fetchAddr), 32'h123456);
  endtask
  task automatic t_regs();
    logic [31:0] exp[5] = '{32'hBEEFA55A, 32'hBEEF, 32'hA55A, 32'hA5, 32'h5A};
    regWrite = '{1'b1, 3'h7, PART_LONG, 32'h89ABCDEF};
    step();
    regWrite = '{1'b1, 3'h2, PART_LONG, 32'h11223344};
    step();
    regWrite = '{1'b1, 3'h2, PART_HIGH, 32'hA5};
    step();
    regWrite = '{1'b1, 3'h2, PART_LOW, 32'h5A};
    step();
    regWrite = '{1'b1, 3'h2, PART_EXT, 32'hBEEF};
    step();
    regWrite.wen = '0;
    readIdx = 3'h2;
    for (int i = 0; i < 5; i++) begin
      readPart = part_e'(i);
      step();
      check("read", readData, exp[i]);
    end
    check("sp", stackPointer, 32'h89ABCDEF);
  endtask
  task automatic t_flags();
    flag_op(OP_ADD, SZ_BYTE, 32'h0F, 32'h1, 32'h10, 8'h0, 8'hA0);
    flag_op(OP_ADD, SZ_WORD, 32'h0FFF, 32'h1, 32'h1000, 8'h0, 8'hA0);
    flag_op(OP_ADD, SZ_LONG, 32'h0FFFFFFF, 32'h1, 32'h10000000, 8'h0, 8'hA0);
    flag_op(OP_ADD, SZ_BYTE, 32'h7F, 32'h1, 32'h80, 8'h0, 8'hAA);
    flag_op(OP_ADD, SZ_BYTE, 32'hFF, 32'h1, 32'h0, 8'h0, 8'hA5);
    flag_op(OP_SUB, SZ_BYTE, 32'h0, 32'h1, 32'hFF, 8'h0, 8'hA9);
    flag_op(OP_SHIFT, SZ_BYTE, 32'h0, 32'h0, 32'h0, 8'h0, 8'hA5);
    flag_op(OP_LDFLAG, SZ_BYTE, 32'h0, 32'h0, 32'h0, 8'h50, 8'h50);
    flag_op(OP_ORFLAG, SZ_BYTE, 32'h0, 32'h0, 32'h0, 8'h0F, 8'h5F);
    flag_op(OP_ANDFLAG, SZ_BYTE, 32'h0, 32'h0, 32'h0, 8'hF0, 8'h50);
    flag_op(OP_XORFLAG, SZ_BYTE, 32'h0, 32'h0, 32'h0, 8'h40, 8'h10);
    flag_op(OP_LDFLAG, SZ_BYTE, 32'h0, 32'h0, 32'h0, 8'h01, 8'h01);
    flag_op(OP_ADDX, SZ_BYTE, 32'h0E, 32'h01, 32'h10, 8'h0, 8'h20);
    flag_op(OP_LDFLAG, SZ_BYTE, 32'h0, 32'h0, 32'h0, 8'h05, 8'h05);
    flag_op(OP_SUBX, SZ_BYTE, 32'h01, 32'h00, 32'h00, 8'h0, 8'h04);
    flag_op(OP_CMP, SZ_WORD, 32'h1000, 32'h0001, 32'h0FFF, 8'h0, 8'h20);
    flag_op(OP_NEG, SZ_LONG, 32'h0, 32'h1, 32'hFFFFFFFF, 8'h0, 8'h29);
    flag_op(OP_LOGIC, SZ_BYTE, 32'h0, 32'h0, 32'h00, 8'h0, 8'h25);
    flag_op(OP_BIT, SZ_BYTE, 32'h0, 32'h0, 32'h0, 8'h0, 8'h24);
    exceptionStart = '1;
    step();
    exceptionStart = '0;
    check("flags", 32'(conditionFlags), 32'hA4);
  endtask
  task automatic t_irq_addr();
    irqRequest = '1;
    nmiRequest = '1;
    step();
    check("nmi", 32'(nmiAccept), 32'h1);
    nmiRequest = '0;
    step();
    check("irq", 32'(irqAccept), 32'h0);
    flag_op(OP_LDFLAG, SZ_BYTE, 32'h0, 32'h0, 32'h0, 8'h40, 8'h40);
    useUiMask = '1;
    step();
    check("irq", 32'(irqAccept), 32'h0);
    useUiMask = '0;
    step();
    check("irq", 32'(irqAccept), 32'h1);
    narrowSpace = '1;
    wideAccess = '1;
    effAddr = 32'hFFF12345;
    step();
    check("addr", 32'(busAddr), 32'h012344);
    narrowSpace = '0;
    effAddr = 32'h00ABCDEF;
    step();
    check("addr", 32'(busAddr), 32'hABCDEE);
    wideAccess = '0;
    step();
    check("addr", 32'(busAddr), 32'hABCDEF);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    step(5);
    t_reset_pc();
    t_regs();
    t_flags();
    t_irq_addr();
    print_verdict();
  end
endmodule
`default_nettype wire
